/* File: hw/pkt_fifo.sv */
// Purpose: Byte FIFO held in flip-flops with synchronous clear
// Assumes: Push ignored when full, pop ignored when empty
// Notes: Clear wins over push and pop in the same cycle
`timescale 1ns/10ps
module pkt_fifo (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Control
	input wire logic i_clear,
	input wire logic i_push,
	input wire logic [7:0] i_wdata,
	input wire logic i_pop,
	// State
	output logic [7:0] o_head,
	output logic [6:0] o_count,
	output logic o_empty,
	output logic o_full
);
	logic [7:0] mem_q [pkt_irq_pkg::FIFO_DEPTH];
	logic [5:0] wr_q;
	logic [5:0] rd_q;
	logic [6:0] cnt_q;
	logic push_ok;
	logic pop_ok;

	assign o_empty = (cnt_q == 7'h00);
	assign o_full = (cnt_q == 7'(pkt_irq_pkg::FIFO_DEPTH));
	assign push_ok = i_push && !o_full;
	assign pop_ok = i_pop && !o_empty;
	assign o_head = mem_q[rd_q];
	assign o_count = cnt_q;

	for (genvar g = 0; g < pkt_irq_pkg::FIFO_DEPTH; g++) begin : g_cell
		always_ff @(posedge i_clk) begin
			if (push_ok && wr_q == 6'(g)) begin
				mem_q[g] <= i_wdata;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_clear) begin
			wr_q <= 6'h00;
			rd_q <= 6'h00;
			cnt_q <= 7'h00;
		end else begin
			if (push_ok) begin
				wr_q <= 6'(wr_q + 6'h01);
			end
			if (pop_ok) begin
				rd_q <= 6'(rd_q + 6'h01);
			end
			cnt_q <= 7'(cnt_q + {6'h00, push_ok} - {6'h00, pop_ok});
		end
	end
endmodule

/* File: hw/pkt_irq_ctrl.sv */
// Purpose: Packet-mode interrupt routing, FIFO keeping and reception rules
// Assumes: Datapath strobes are on i_clk; host uses the register port
// Notes: Register read data stands only in the cycle after the read strobe
`timescale 1ns/10ps
module pkt_irq_ctrl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Receive datapath
	input wire logic i_sync_det,
	input wire logic i_addr_match,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_crc_match,
	input wire logic i_signal_strength_event_above,
	// Transmit datapath
	input wire logic i_tx_ready,
	input wire logic i_tx_take,
	input wire logic i_tx_done,
	output logic o_tx_start,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	// Datapath settings
	output logic [1:0] o_preamble_size,
	output logic [1:0] o_sync_tolerance,
	output logic [6:0] o_payload_length,
	output logic o_variable_format,
	output logic o_crc_enable,
	output logic o_node_filter,
	// Interrupt lines
	output logic o_interrupt_line_a,
	output logic o_interrupt_line_b
);
	// ******************************
	// Declarations
	// ******************************
	logic [7:0] mode_q;
	logic [7:0] irqsel_q;
	logic [7:0] thresh_q;
	logic [7:0] plen_q;
	logic [7:0] pktctl_q;
	logic [7:0] fifoctl_q;
	logic [7:0] rdata_q;
	pkt_irq_pkg::rx_state_type rx_state_q;
	pkt_irq_pkg::tx_state_type tx_state_q;
	logic [7:0] rx_cnt_q;
	logic [7:0] exp_q;
	logic payload_ready_q;
	logic check_good_q;
	logic node_match_q;
	logic sync_seen_q;
	logic check_status_q;
	logic byte_written_q;
	logic send_complete_q;
	logic tx_start_q;
	logic tx_valid_q;
	logic [7:0] tx_data_q;
	pkt_irq_pkg::chip_mode_type chip_mode;
	logic is_rx;
	logic is_tx;
	logic is_standby;
	logic packet;
	logic sel_a_tx;
	logic [7:0] fifo_head;
	logic [6:0] fifo_count;
	logic fifo_empty;
	logic fifo_full;
	logic fifo_thresh;
	logic fifo_clear;
	logic fifo_push;
	logic fifo_pop;
	logic host_push;
	logic host_pop;
	logic rx_push;
	logic tx_pop;
	logic sync_accept;
	logic [7:0] exp_now;
	logic rx_last;
	logic drop_len;
	logic crc_fail_clear;
	logic accept_last;
	logic rx_discard;
	logic hold_done;
	logic rx_abort;
	logic tx_go;
	logic tx_clear;
	logic match_src;

	function automatic logic mode_is(input logic [7:0] m,
		input pkt_irq_pkg::chip_mode_type want);
		return m[pkt_irq_pkg::MODE_CHIP_MSB:pkt_irq_pkg::MODE_CHIP_LSB]
			== want;
	endfunction

	// ******************************
	// Mode decode
	// ******************************
	assign chip_mode = pkt_irq_pkg::chip_mode_type'(
		mode_q[pkt_irq_pkg::MODE_CHIP_MSB:pkt_irq_pkg::MODE_CHIP_LSB]);
	assign is_rx = mode_is(mode_q, pkt_irq_pkg::MODE_RX);
	assign is_tx = mode_is(mode_q, pkt_irq_pkg::MODE_TX);
	assign is_standby = mode_is(mode_q, pkt_irq_pkg::MODE_STANDBY);
	assign packet = mode_q[pkt_irq_pkg::MODE_DATA_HIGH];
	assign sel_a_tx = irqsel_q[pkt_irq_pkg::SEL_A_TX];

	// ******************************
	// Register port
	// ******************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			mode_q <= pkt_irq_pkg::RST_MODE;
			irqsel_q <= pkt_irq_pkg::RST_IRQSEL;
			thresh_q <= pkt_irq_pkg::RST_THRESH;
			plen_q <= pkt_irq_pkg::RST_PLEN;
			pktctl_q <= pkt_irq_pkg::RST_PKTCTL;
			fifoctl_q <= pkt_irq_pkg::RST_FIFOCTL;
		end else if (i_wr) begin
			case (i_addr)
				pkt_irq_pkg::ADDR_MODE: mode_q <= i_wdata & pkt_irq_pkg::MASK_MODE;
				pkt_irq_pkg::ADDR_IRQSEL: begin
					irqsel_q <= i_wdata & pkt_irq_pkg::MASK_IRQSEL;
				end
				pkt_irq_pkg::ADDR_THRESH: begin
					thresh_q <= i_wdata & pkt_irq_pkg::MASK_THRESH;
				end
				pkt_irq_pkg::ADDR_PLEN: plen_q <= i_wdata;
				pkt_irq_pkg::ADDR_PKTCTL: begin
					pktctl_q <= i_wdata & pkt_irq_pkg::MASK_PKTCTL;
				end
				// Fill bits are stored but steer nothing
				pkt_irq_pkg::ADDR_FIFOCTL: begin
					fifoctl_q <= i_wdata & pkt_irq_pkg::MASK_FIFOCTL;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !i_rd) begin
			rdata_q <= 8'h00;
		end else begin
			case (i_addr)
				pkt_irq_pkg::ADDR_MODE: rdata_q <= mode_q;
				pkt_irq_pkg::ADDR_IRQSEL: rdata_q <= irqsel_q;
				pkt_irq_pkg::ADDR_THRESH: rdata_q <= thresh_q;
				pkt_irq_pkg::ADDR_PLEN: rdata_q <= plen_q;
				pkt_irq_pkg::ADDR_PKTCTL: begin
					rdata_q <= {pktctl_q[7:1], check_status_q};
				end
				pkt_irq_pkg::ADDR_FIFOCTL: rdata_q <= fifoctl_q;
				pkt_irq_pkg::ADDR_STATUS: begin
					rdata_q <= {payload_ready_q, check_good_q, node_match_q,
						sync_seen_q, fifo_empty, fifo_full, fifo_thresh,
						send_complete_q};
				end
				// An empty FIFO reads zero, not a stale cell
				pkt_irq_pkg::ADDR_FIFO: begin
					rdata_q <= (host_pop && !fifo_empty) ? fifo_head : 8'h00;
				end
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// ******************************
	// FIFO access
	// ******************************
	assign host_push = i_wr && i_addr == pkt_irq_pkg::ADDR_FIFO && (is_tx
		|| (is_standby && !fifoctl_q[pkt_irq_pkg::FCTL_DIR]));
	assign host_pop = i_rd && i_addr == pkt_irq_pkg::ADDR_FIFO && (is_rx
		|| (is_standby && fifoctl_q[pkt_irq_pkg::FCTL_DIR]));
	assign tx_pop = tx_state_q == pkt_irq_pkg::TX_SEND && i_tx_take
		&& !fifo_empty;
	assign fifo_push = host_push || rx_push;
	assign fifo_pop = host_pop || tx_pop;
	assign fifo_clear = rx_discard || tx_clear;
	assign fifo_thresh = fifo_count > {1'b0, thresh_q[5:0]};

	pkt_fifo u_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_clear(fifo_clear),
		.i_push(fifo_push),
		.i_wdata(i_rx_data & {8{rx_push}} | i_wdata & {8{host_push}}),
		.i_pop(fifo_pop),
		.o_head(fifo_head),
		.o_count(fifo_count),
		.o_empty(fifo_empty),
		.o_full(fifo_full)
	);

	// ******************************
	// Reception
	// ******************************
	assign sync_accept = rx_state_q == pkt_irq_pkg::RX_IDLE && is_rx
		&& packet && i_sync_det && fifo_empty;
	assign exp_now = (plen_q[pkt_irq_pkg::PLEN_VAR] && rx_cnt_q == 8'h00)
		? 8'(i_rx_data + 8'h01)
		: (plen_q[pkt_irq_pkg::PLEN_VAR] ? exp_q : {1'b0, plen_q[6:0]});
	assign rx_last = 8'(rx_cnt_q + 8'h01) == exp_now;
	assign drop_len = plen_q[pkt_irq_pkg::PLEN_VAR] && rx_cnt_q == 8'h00
		&& i_rx_data > {1'b0, plen_q[6:0]};
	assign crc_fail_clear = pktctl_q[pkt_irq_pkg::PKT_CRC] && !i_crc_match
		&& fifoctl_q[pkt_irq_pkg::FCTL_AUTOCLR] && is_rx;
	// Bytes only land while a packet body is open
	assign rx_push = rx_state_q == pkt_irq_pkg::RX_BODY && is_rx
		&& i_rx_valid && !drop_len;
	assign accept_last = rx_push && rx_last && !crc_fail_clear;
	assign rx_discard = rx_state_q == pkt_irq_pkg::RX_BODY && is_rx
		&& i_rx_valid && (drop_len || (rx_last && crc_fail_clear));
	assign hold_done = rx_state_q == pkt_irq_pkg::RX_HOLD && fifo_empty;
	assign rx_abort = rx_discard
		|| (rx_state_q == pkt_irq_pkg::RX_BODY && !is_rx);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rx_state_q <= pkt_irq_pkg::RX_IDLE;
			rx_cnt_q <= 8'h00;
			exp_q <= 8'h00;
		end else begin
			case (rx_state_q)
				pkt_irq_pkg::RX_IDLE: begin
					rx_cnt_q <= 8'h00;
					if (sync_accept) begin
						rx_state_q <= pkt_irq_pkg::RX_BODY;
					end
				end
				pkt_irq_pkg::RX_BODY: begin
					if (rx_abort) begin
						rx_state_q <= pkt_irq_pkg::RX_IDLE;
					end else if (accept_last) begin
						rx_state_q <= pkt_irq_pkg::RX_HOLD;
					end else if (rx_push) begin
						rx_cnt_q <= 8'(rx_cnt_q + 8'h01);
						exp_q <= exp_now;
					end
				end
				// Single packet: stay until it is read empty
				pkt_irq_pkg::RX_HOLD: begin
					if (hold_done) begin
						rx_state_q <= pkt_irq_pkg::RX_IDLE;
					end
				end
				default: rx_state_q <= pkt_irq_pkg::RX_IDLE;
			endcase
		end
	end

	// ******************************
	// Sticky flags and byte-written pulse
	// ******************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			payload_ready_q <= 1'b0;
			check_good_q <= 1'b0;
		end else if (accept_last) begin
			payload_ready_q <= 1'b1;
			check_good_q <= pktctl_q[pkt_irq_pkg::PKT_CRC] && i_crc_match;
		end else if (hold_done) begin
			payload_ready_q <= 1'b0;
			check_good_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			node_match_q <= 1'b0;
			sync_seen_q <= 1'b0;
		end else begin
			if (sync_accept) begin
				sync_seen_q <= 1'b1;
			end else if (hold_done || rx_abort) begin
				sync_seen_q <= 1'b0;
			end
			if (rx_state_q == pkt_irq_pkg::RX_BODY && i_addr_match
				&& pktctl_q[pkt_irq_pkg::PKT_FILT] && !rx_abort) begin
				node_match_q <= 1'b1;
			end else if (hold_done || rx_abort) begin
				node_match_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			check_status_q <= 1'b0;
		end else if (accept_last) begin
			check_status_q <= i_crc_match;
		end else if ((hold_done && is_rx) || sync_accept) begin
			check_status_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			byte_written_q <= 1'b0;
		end else begin
			byte_written_q <= rx_push;
		end
	end

	assign match_src = pktctl_q[pkt_irq_pkg::PKT_FILT]
		? node_match_q : sync_seen_q;

	// ******************************
	// Transmission
	// ******************************
	assign tx_go = is_tx && packet && i_tx_ready
		&& (sel_a_tx ? !fifo_empty : fifo_thresh);
	assign tx_clear = tx_state_q == pkt_irq_pkg::TX_SEND && is_tx
		&& i_tx_done && sel_a_tx;

	// Without the clear, surplus bytes wait for the next packet
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tx_state_q <= pkt_irq_pkg::TX_IDLE;
			tx_start_q <= 1'b0;
		end else begin
			tx_start_q <= 1'b0;
			case (tx_state_q)
				pkt_irq_pkg::TX_IDLE: begin
					if (tx_go) begin
						tx_state_q <= pkt_irq_pkg::TX_SEND;
						tx_start_q <= 1'b1;
					end
				end
				pkt_irq_pkg::TX_SEND: begin
					if (!is_tx || i_tx_done) begin
						tx_state_q <= pkt_irq_pkg::TX_IDLE;
					end
				end
				default: tx_state_q <= pkt_irq_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			send_complete_q <= 1'b0;
		end else if (tx_state_q == pkt_irq_pkg::TX_SEND && i_tx_done) begin
			send_complete_q <= 1'b1;
		end else if (tx_start_q) begin
			send_complete_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else begin
			tx_valid_q <= tx_pop;
			if (tx_pop) begin
				tx_data_q <= fifo_head;
			end
		end
	end

	// ******************************
	// Interrupt routing and outputs
	// ******************************
	pkt_irq_route u_route (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_mode(chip_mode),
		.i_packet(packet),
		.i_a_rx_sel(irqsel_q[pkt_irq_pkg::SEL_A_RX_LSB +: 2]),
		.i_b_rx_sel(irqsel_q[pkt_irq_pkg::SEL_B_RX_LSB +: 2]),
		.i_a_tx_sel(sel_a_tx),
		.i_b_tx_sel(irqsel_q[pkt_irq_pkg::SEL_B_TX]),
		.i_payload_ready(payload_ready_q),
		.i_byte_written(byte_written_q),
		.i_fifo_empty(fifo_empty),
		.i_match(match_src),
		.i_check_good(check_good_q),
		.i_fifo_full(fifo_full),
		.i_strength(i_signal_strength_event_above),
		.i_fifo_thresh(fifo_thresh),
		.i_send_complete(send_complete_q),
		.o_line_a(o_interrupt_line_a),
		.o_line_b(o_interrupt_line_b)
	);

	assign o_rdata = rdata_q;
	assign o_tx_start = tx_start_q;
	assign o_tx_valid = tx_valid_q;
	assign o_tx_data = tx_data_q;
	assign o_preamble_size = pktctl_q[pkt_irq_pkg::PKT_PRE_LSB +: 2];
	assign o_sync_tolerance = pktctl_q[pkt_irq_pkg::PKT_TOL_LSB +: 2];
	assign o_payload_length = plen_q[6:0];
	assign o_variable_format = plen_q[pkt_irq_pkg::PLEN_VAR];
	assign o_crc_enable = pktctl_q[pkt_irq_pkg::PKT_CRC];
	assign o_node_filter = pktctl_q[pkt_irq_pkg::PKT_FILT];

	// ******************************
	// Assertions
	// ******************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_tx_b_done;
		is_tx && packet && irqsel_q[pkt_irq_pkg::SEL_B_TX] ##1
		is_tx && packet && irqsel_q[pkt_irq_pkg::SEL_B_TX];
	endsequence

	a_ready_hold: assert property (
		payload_ready_q && !fifo_empty && !fifo_clear |=> payload_ready_q)
		else $error("payload ready dropped before read out");
	a_ready_set: assert property (
		accept_last |=> payload_ready_q && rx_state_q == pkt_irq_pkg::RX_HOLD)
		else $error("payload ready missing after last byte");
	a_rx_busy: assert property (
		rx_state_q == pkt_irq_pkg::RX_IDLE && !fifo_empty
		|=> rx_state_q == pkt_irq_pkg::RX_IDLE)
		else $error("reception began with bytes left in the FIFO");
	a_status_load: assert property (
		accept_last |=> check_status_q == $past(i_crc_match))
		else $error("check status not loaded with the flags");
	a_status_clear: assert property (
		hold_done && is_rx |=> !check_status_q)
		else $error("check status kept after read out in receive");
	a_fail_clear: assert property (
		rx_discard |=> fifo_empty && !payload_ready_q && !check_good_q)
		else $error("failed packet left data or a flag");
	a_tx_start: assert property (
		tx_state_q == pkt_irq_pkg::TX_IDLE && is_tx && packet && sel_a_tx
		&& i_tx_ready && !fifo_empty |=> o_tx_start ##1 !o_tx_start)
		else $error("transmission did not start on a loaded FIFO");
	a_tx_surplus: assert property (
		tx_clear |=> fifo_count == 7'h00)
		else $error("surplus bytes survived the send");
	a_tx_keep: assert property (
		tx_state_q == pkt_irq_pkg::TX_SEND && i_tx_done && !sel_a_tx
		&& !fifo_push && !fifo_pop |=> fifo_count == $past(fifo_count))
		else $error("surplus bytes lost with keep selected");
	a_line_b_tx: assert property (
		s_tx_b_done |-> o_interrupt_line_b == $past(send_complete_q))
		else $error("line B does not follow send complete");
	a_no_sync: assert property (
		rx_state_q != pkt_irq_pkg::RX_BODY && i_rx_valid && !host_push
		|=> fifo_count <= $past(fifo_count))
		else $error("byte stored without an accepted sync");
endmodule

/* File: hw/pkt_irq_pkg.sv */
// Purpose: Constants and types for the packet-mode interrupt and FIFO control
// Assumes: Eight-bit register port, one 100 MHz clock, synchronous reset
// Notes: Every user of this package writes pkt_irq_pkg::name
package pkt_irq_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int FIFO_DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int CNT_W = 7;

	// ******************************
	// Register offsets
	// ******************************
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_IRQSEL = 4'h1;
	localparam logic [3:0] ADDR_THRESH = 4'h2;
	localparam logic [3:0] ADDR_PLEN = 4'h3;
	localparam logic [3:0] ADDR_PKTCTL = 4'h4;
	localparam logic [3:0] ADDR_FIFOCTL = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam logic [3:0] ADDR_FIFO = 4'h7;

	// ******************************
	// Field positions
	// ******************************
	localparam int MODE_CHIP_MSB = 7;
	localparam int MODE_CHIP_LSB = 5;
	localparam int MODE_DATA_HIGH = 1;
	localparam int SEL_A_RX_LSB = 6;
	localparam int SEL_B_RX_LSB = 4;
	localparam int SEL_A_TX = 3;
	localparam int SEL_B_TX = 2;
	localparam int PLEN_VAR = 7;
	localparam int PKT_PRE_LSB = 6;
	localparam int PKT_TOL_LSB = 4;
	localparam int PKT_FILT = 3;
	localparam int PKT_CRC = 2;
	localparam int FCTL_AUTOCLR = 7;
	localparam int FCTL_DIR = 6;

	// ******************************
	// Reset values and write masks
	// ******************************
	localparam logic [7:0] RST_MODE = 8'h22;
	localparam logic [7:0] RST_IRQSEL = 8'h00;
	localparam logic [7:0] RST_THRESH = 8'h0f;
	localparam logic [7:0] RST_PLEN = 8'h08;
	localparam logic [7:0] RST_PKTCTL = 8'h00;
	localparam logic [7:0] RST_FIFOCTL = 8'h80;
	localparam logic [7:0] MASK_MODE = 8'he3;
	localparam logic [7:0] MASK_IRQSEL = 8'hfc;
	localparam logic [7:0] MASK_THRESH = 8'h3f;
	localparam logic [7:0] MASK_PKTCTL = 8'hfc;
	localparam logic [7:0] MASK_FIFOCTL = 8'hf0;

	typedef enum logic [2:0] {
		MODE_SLEEP = 3'h0,
		MODE_STANDBY = 3'h1,
		MODE_SYNTH = 3'h2,
		MODE_RX = 3'h3,
		MODE_TX = 3'h4
	} chip_mode_type;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_BODY = 2'h1,
		RX_HOLD = 2'h2
	} rx_state_type;

	typedef enum logic [0:0] {
		TX_IDLE = 1'h0,
		TX_SEND = 1'h1
	} tx_state_type;
endpackage

/* File: hw/pkt_irq_route.sv */
// Purpose: Routes interrupt sources onto the two interrupt lines by mode
// Assumes: Sources come from logic on the same clock
// Notes: Lines are registered, one cycle behind their source
`timescale 1ns/10ps
module pkt_irq_route (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Mode and selectors
	input wire pkt_irq_pkg::chip_mode_type i_mode,
	input wire logic i_packet,
	input wire logic [1:0] i_a_rx_sel,
	input wire logic [1:0] i_b_rx_sel,
	input wire logic i_a_tx_sel,
	input wire logic i_b_tx_sel,
	// Sources
	input wire logic i_payload_ready,
	input wire logic i_byte_written,
	input wire logic i_fifo_empty,
	input wire logic i_match,
	input wire logic i_check_good,
	input wire logic i_fifo_full,
	input wire logic i_strength,
	input wire logic i_fifo_thresh,
	input wire logic i_send_complete,
	// Lines
	output logic o_line_a,
	output logic o_line_b
);
	logic a_d;
	logic b_d;

	function automatic logic pick4(input logic [1:0] s, input logic [3:0] v);
		return v[s];
	endfunction

	always_comb begin
		a_d = 1'b0;
		b_d = 1'b0;
		if (i_packet) begin
			case (i_mode)
				pkt_irq_pkg::MODE_RX: begin
					a_d = pick4(i_a_rx_sel, {i_match, i_fifo_empty,
						i_byte_written, i_payload_ready});
					b_d = pick4(i_b_rx_sel, {i_fifo_thresh, i_strength,
						i_fifo_full, i_check_good});
				end
				pkt_irq_pkg::MODE_STANDBY: begin
					a_d = pick4(i_a_rx_sel, {1'b0, i_fifo_empty, 2'b00});
					b_d = pick4(i_b_rx_sel, {i_fifo_thresh, 1'b0,
						i_fifo_full, 1'b0});
				end
				pkt_irq_pkg::MODE_TX: begin
					a_d = i_a_tx_sel ? i_fifo_empty : i_fifo_thresh;
					b_d = i_b_tx_sel ? i_send_complete : i_fifo_full;
				end
				default: begin
					a_d = 1'b0;
					b_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_line_a <= 1'b0;
			o_line_b <= 1'b0;
		end else begin
			o_line_a <= a_d;
			o_line_b <= b_d;
		end
	end
endmodule

/* File: test/pkt_irq_ctrl_test.sv */
// Purpose: Self-checking bench for packet interrupt control
// Assumes: Register port with read data one cycle after strobe
// Notes: Transmit datapath driven by hand in its own test
`timescale 1ns/10ps
module pkt_irq_ctrl_test;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, w = 1'b0, r = 1'b0, go = 1'b0;
	logic crc = 1'b0, sync, valid, la, lb, idle = 1'b0;
	logic rdy = 1'b0, take = 1'b0, done = 1'b0, ts, tv, vfmt, crce, filt;
	logic [1:0] pre, tol;
	logic [6:0] plen_o;
	logic [7:0] td;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, rx_data;
	int fail_count = 0, checked = 0;
	logic [17:0] rows [8] = '{{8'h22, 8'h80, 2'b10}, {8'h22, 8'h40, 2'b00},
		{8'h22, 8'h00, 2'b00}, {8'h22, 8'h10, 2'b00},
		{8'h62, 8'h80, 2'b10}, {8'h82, 8'h08, 2'b10},
		{8'h82, 8'h00, 2'b00}, {8'h02, 8'h80, 2'b00}};
	always #5 i_clk = ~i_clk;
	pkt_irq_ctrl uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(w), .i_rd(r), .o_rdata(rdata),
		.i_sync_det(sync), .i_addr_match(idle), .i_rx_valid(valid),
		.i_rx_data(rx_data), .i_crc_match(crc), .i_signal_strength_event_above(idle),
		.i_tx_ready(rdy), .i_tx_take(take), .i_tx_done(done),
		.o_tx_start(ts), .o_tx_valid(tv), .o_tx_data(td),
		.o_preamble_size(pre), .o_sync_tolerance(tol),
		.o_payload_length(plen_o), .o_variable_format(vfmt),
		.o_crc_enable(crce), .o_node_filter(filt), .o_interrupt_line_a(la),
		.o_interrupt_line_b(lb));
	rx_source #(.LEN(2)) src (.i_clk(i_clk), .i_go(go),
		.o_sync(sync), .o_valid(valid), .o_data(rx_data));
	// ****
	// Tasks
	// ****
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task settings(input logic [7:0] e, input logic [7:0] l);
		chk({pre, tol, vfmt, crce, filt, 1'b0}, e);
		chk({1'b0, plen_o}, l);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		w <= 1'b1;
		@(posedge i_clk);
		w <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk);
		addr <= a;
		r <= 1'b1;
		@(posedge i_clk);
		r <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task packet(input logic c);
		@(posedge i_clk);
		crc <= c;
		go <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask
	task end_sim;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		end_sim;
	end
	// ****
	// Sequence
	// ****
	initial begin
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(4'h0, 8'h22);
		rd(4'h5, 8'h80);
		rd(4'h9, 8'h00);
		settings(8'h00, 8'h08);
		foreach (rows[i]) begin
			wr(4'h0, rows[i][17:10]);
			wr(4'h1, rows[i][9:2]);
			repeat (3) @(posedge i_clk);
			chk({6'h00, la, lb}, {6'h00, rows[i][1:0]});
			$display("row %0d done", i);
		end
		wr(4'h3, 8'h02);
		wr(4'h4, 8'h74);
		wr(4'h5, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h62);
		settings(8'h74, 8'h02);
		packet(1'b1);
		chk({6'h00, la, lb}, 8'h03);
		rd(4'h4, 8'h75);
		packet(1'b1);
		rd(4'h7, 8'ha0);
		rd(4'h7, 8'ha1);
		repeat (3) @(posedge i_clk);
		chk({6'h00, la, lb}, 8'h00);
		rd(4'h4, 8'h74);
		$display("receive test done");
		wr(4'h5, 8'h80);
		packet(1'b0);
		chk({6'h00, la, lb}, 8'h00);
		rd(4'h7, 8'h00);
		rd(4'h6, 8'h08);
		$display("autoclear test done");
		packet(1'b1);
		chk({6'h00, la, lb}, 8'h03);
		wr(4'h5, 8'hc0);
		wr(4'h0, 8'h22);
		rd(4'h7, 8'hd0);
		rd(4'h7, 8'hd1);
		rd(4'h4, 8'h75);
		wr(4'h0, 8'h62);
		rd(4'h4, 8'h75);
		packet(1'b0);
		rd(4'h4, 8'h74);
		$display("standby read test done");
		wr(4'h5, 8'h80);
		wr(4'h0, 8'h22);
		wr(4'h1, 8'h0c);
		wr(4'h7, 8'h11);
		wr(4'h7, 8'h22);
		wr(4'h7, 8'h33);
		wr(4'h0, 8'h82);
		@(posedge i_clk) rdy <= 1'b1;
		@(posedge i_clk);
		#1 chk({7'h00, ts}, 8'h01);
		@(posedge i_clk) take <= 1'b1;
		@(posedge i_clk) take <= 1'b0;
		#1 chk({7'h00, tv}, 8'h01);
		chk(td, 8'h11);
		@(posedge i_clk) take <= 1'b1;
		@(posedge i_clk) take <= 1'b0;
		#1 chk(td, 8'h22);
		@(posedge i_clk) done <= 1'b1;
		@(posedge i_clk) done <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({6'h00, la, lb}, 8'h03);
		rd(4'h6, 8'h09);
		@(posedge i_clk) rdy <= 1'b0;
		repeat (4) @(posedge i_clk);
		wr(4'h0, 8'h02);
		repeat (2) @(posedge i_clk);
		chk({6'h00, la, lb}, 8'h00);
		$display("transmit test done");
		@(posedge i_clk) i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(4'h1, 8'h00);
		rd(4'h6, 8'h08);
		settings(8'h00, 8'h08);
		chk({6'h00, la, lb}, 8'h00);
		$display("reset test done");
		end_sim;
	end
endmodule

/* File: test/rx_source.sv */
// Purpose: Receive datapath stand-in feeding one packet per request
// Assumes: Fixed-length packets of LEN bytes, one byte per cycle
// Notes: Data lines show inverted last byte once released
`timescale 1ns/10ps
module rx_source #(parameter int LEN = 2) (
	// Control
	input wire logic i_clk,
	input wire logic i_go,
	// Datapath
	output logic o_sync,
	output logic o_valid,
	output logic [7:0] o_data
);
	logic [7:0] base = 8'ha0;
	initial begin
		o_sync = 1'b0;
		o_valid = 1'b0;
		o_data = 8'h00;
	end
	// Sync always leads the body
	always @(posedge i_clk) begin
		if (i_go) begin
			o_sync <= 1'b1;
			for (int k = 0; k < LEN; k++) begin
				@(posedge i_clk);
				o_sync <= 1'b0;
				o_valid <= 1'b1;
				o_data <= base + 8'(k);
			end
			@(posedge i_clk);
			o_valid <= 1'b0;
			o_data <= ~o_data;
			base <= base + 8'h10;
		end
	end
endmodule
